// ===== verilog/tla_pkg.sv
// Constants for the temperature limit alarm block.
// Assumes a 32-bit APB slave view with one word per register.
package tla_pkg;
   localparam int TLA_TW = 16;
   localparam int TLA_AW = 8;
   localparam int TLA_DW = 32;
   // Register byte offsets
   localparam logic [7:0] TLA_OFF_CTRL = 8'h00;
   localparam logic [7:0] TLA_OFF_UPPER = 8'h04;
   localparam logic [7:0] TLA_OFF_LOWER = 8'h08;
   localparam logic [7:0] TLA_OFF_CRIT = 8'h0C;
   localparam logic [7:0] TLA_OFF_HYST = 8'h10;
   localparam logic [7:0] TLA_OFF_TEMP = 8'h14;
   localparam logic [7:0] TLA_OFF_STATUS = 8'h18;
   localparam logic [7:0] TLA_OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] TLA_OFF_IRQ_MASK = 8'h20;
   // Control bits
   localparam int TLA_CTRL_COMP = 0;
   localparam int TLA_CTRL_APOL = 1;
   localparam int TLA_CTRL_CPOL = 2;
   localparam int TLA_CTRL_SHDN = 3;
   localparam int TLA_CTRL_W = 4;
   // Status bits
   localparam int TLA_ST_ALARM = 0;
   localparam int TLA_ST_OVER = 1;
   localparam int TLA_ST_UNDER = 2;
   localparam int TLA_ST_CRIT = 3;
   localparam int TLA_ST_APIN = 4;
   localparam int TLA_ST_CPIN = 5;
   localparam int TLA_ST_W = 6;
   // Interrupt event bits
   localparam int TLA_EV_OVER = 0;
   localparam int TLA_EV_UNDER = 1;
   localparam int TLA_EV_CRIT = 2;
   localparam int TLA_EV_CONV = 3;
   localparam int TLA_EV_W = 4;
   // Reset values
   localparam logic [3:0] TLA_CTRL_RST = 4'h0;
   localparam logic [15:0] TLA_UPPER_RST = 16'h2000;
   localparam logic [15:0] TLA_LOWER_RST = 16'h0500;
   localparam logic [15:0] TLA_CRIT_RST = 16'h4000;
   localparam logic [15:0] TLA_HYST_RST = 16'h0280;
   localparam logic [15:0] TLA_TEMP_RST = 16'h0000;
   localparam logic [3:0] TLA_MASK_RST = 4'h0;
   typedef enum logic [2:0] {
      TLA_S_IDLE = 3'b001,
      TLA_S_ACCESS = 3'b010,
      TLA_S_DONE = 3'b100
   } tla_apb_st_t;
endpackage

// ===== verilog/tla_limit_core.sv
// Limit compare and alarm state for one alarm output.
// Assumes eval is a one-cycle pulse per new result.
`timescale 1ns/1ps
module tla_limit_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic eval,
   input wire logic [15:0] temp,
   input wire logic [15:0] upper,
   input wire logic [15:0] lower,
   input wire logic [15:0] hyst,
   input wire logic lower_en,
   input wire logic comp_mode,
   input wire logic shutdown,
   input wire logic rd_clr,
   input wire logic mode_chg,
   output logic alarm,
   output logic over_r,
   output logic under_r,
   output logic over_evt,
   output logic under_evt
);
   logic signed [16:0] t_s;
   logic signed [16:0] up_s;
   logic signed [16:0] lo_s;
   logic signed [16:0] up_rel;
   logic signed [16:0] lo_rel;
   logic hi_hit;
   logic lo_hit;
   logic hi_rel;
   logic lo_relc;
   logic over_nxt;
   logic under_nxt;

   assign t_s = {temp[15], temp}; // see RULE10
   assign up_s = {upper[15], upper};
   assign lo_s = {lower[15], lower};
   assign up_rel = up_s - $signed({1'b0, hyst});
   assign lo_rel = lo_s + $signed({1'b0, hyst});
   assign hi_hit = eval && (t_s > up_s); // see RULE3
   assign lo_hit = eval && lower_en && (t_s < lo_s); // see RULE3
   assign hi_rel = eval && (t_s < up_rel); // see RULE4
   assign lo_relc = eval && (t_s > lo_rel); // see RULE4
   assign over_evt = hi_hit;
   assign under_evt = lo_hit;
   assign alarm = over_r | under_r;

   always_comb begin
      over_nxt = over_r;
      under_nxt = under_r;
      if (mode_chg) begin
         over_nxt = 1'b0;
         under_nxt = 1'b0;
      end else if (comp_mode) begin
         // Shutdown leaves state alone here, see RULE5
         if (hi_hit) begin
            over_nxt = 1'b1;
         end else if (hi_rel) begin
            over_nxt = 1'b0;
         end
         if (lo_hit) begin
            under_nxt = 1'b1;
         end else if (lo_relc) begin
            under_nxt = 1'b0;
         end
      end else begin
         if (shutdown) begin
            over_nxt = 1'b0; // see RULE8
            under_nxt = 1'b0;
         end else if (hi_hit || lo_hit) begin
            // New result wins over a read clear, see RULE7
            over_nxt = over_r | hi_hit;
            under_nxt = under_r | lo_hit;
         end else if (rd_clr) begin
            over_nxt = 1'b0; // see RULE6
            under_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         over_r <= 1'b0;
         under_r <= 1'b0;
      end else begin
         over_r <= over_nxt;
         under_r <= under_nxt;
      end
   end
endmodule

// ===== verilog/tla_irq_ctrl.sv
// Sticky event flags with write-one-to-clear and mask.
// Assumes wr_clr is a one-cycle pulse with its clear pattern.
`timescale 1ns/1ps
module tla_irq_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] events,
   input wire logic wr_clr,
   input wire logic [3:0] clr_bits,
   input wire logic [3:0] mask,
   output logic [3:0] stat_r,
   output logic irq_r
);
   logic [3:0] stat_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_bit
         // Set wins over clear
         assign stat_nxt[gi] = events[gi] | (stat_r[gi] & ~(wr_clr & clr_bits[gi]));
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 4'h0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_nxt & mask);
      end
   end
endmodule

// ===== verilog/tla_top.sv
// Temperature limit alarm: APB registers, limit checks, open-drain alarm pins.
// Assumes conv_valid pulses once per finished conversion with conv_result.
// Functional notes
// RULE1: Alarm outputs run in comparator or latching interrupt mode, chosen by control.
// RULE2: After reset the alarm outputs use latching interrupt mode.
// RULE3: Alarm asserts when temperature is above upper or below lower limit.
// RULE4: Comparator mode releases below upper minus hysteresis or above lower plus it.
// RULE5: In comparator mode shutdown keeps the alarm state.
// RULE6: In interrupt mode any completed register read clears the latched alarm.
// RULE7: After clearing, interrupt mode reasserts only on a new out-of-limit result.
// RULE8: In interrupt mode shutdown clears the latched alarm.
// RULE9: Each alarm output has a selectable active level before the open-drain pin.
// RULE10: Limits are checked once per conversion with signed two's complement math.
`timescale 1ns/1ps
module tla_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_valid,
   input wire logic [15:0] conv_result,
   input wire logic alarm_pin_in,
   output logic alarm_pin_out,
   output logic alarm_pin_oe_n,
   input wire logic critical_alarm_output_in,
   output logic critical_alarm_output_out,
   output logic critical_alarm_output_oe_n,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [15:0] tla_merge16(
      input logic [15:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [15:0] res;
      res = old_v;
      if (strb[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction

   function automatic logic tla_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         tla_pkg::TLA_OFF_CTRL,
         tla_pkg::TLA_OFF_UPPER,
         tla_pkg::TLA_OFF_LOWER,
         tla_pkg::TLA_OFF_CRIT,
         tla_pkg::TLA_OFF_HYST,
         tla_pkg::TLA_OFF_TEMP,
         tla_pkg::TLA_OFF_STATUS,
         tla_pkg::TLA_OFF_IRQ_STAT,
         tla_pkg::TLA_OFF_IRQ_MASK: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   tla_pkg::tla_apb_st_t st_r;
   tla_pkg::tla_apb_st_t st_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [3:0] ctrl_r;
   logic [15:0] upper_r;
   logic [15:0] lower_r;
   logic [15:0] crit_r;
   logic [15:0] hyst_r;
   logic [15:0] temp_r;
   logic [3:0] mask_r;
   logic eval_r;
   logic rd_clr_r;
   logic mode_chg;
   logic acc_done;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_mux;
   logic a_alarm;
   logic a_over;
   logic a_under;
   logic a_over_evt;
   logic a_under_evt;
   logic c_alarm;
   logic c_over;
   logic c_under_unused;
   logic c_over_evt;
   logic c_under_evt_unused;
   logic [3:0] events;
   logic [3:0] irq_stat;
   logic irq_r;
   logic alarm_oe_n_r;
   logic crit_oe_n_r;
   logic [5:0] status;
   logic [3:0] ctrl_nxt;
   logic shutdown;
   logic comp_mode;

   assign shutdown = ctrl_r[tla_pkg::TLA_CTRL_SHDN];
   assign comp_mode = ctrl_r[tla_pkg::TLA_CTRL_COMP];

   ////////////////////////////////////////////////////////////////////////
   // APB phase tracking

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         tla_pkg::TLA_S_IDLE: begin
            if (psel && !penable) begin
               st_nxt = tla_pkg::TLA_S_ACCESS;
            end
         end
         tla_pkg::TLA_S_ACCESS: begin
            st_nxt = tla_pkg::TLA_S_DONE;
         end
         tla_pkg::TLA_S_DONE: begin
            if (psel && !penable) begin
               st_nxt = tla_pkg::TLA_S_ACCESS;
            end else begin
               st_nxt = tla_pkg::TLA_S_IDLE;
            end
         end
         default: begin
            st_nxt = tla_pkg::TLA_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= tla_pkg::TLA_S_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign acc_done = psel && penable && pready_r;
   assign wr_en = acc_done && pwrite && !pslverr_r;
   assign rd_en = acc_done && !pwrite && !pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= (st_nxt == tla_pkg::TLA_S_ACCESS);
         if (psel && !penable) begin
            pslverr_r <= !tla_mapped(paddr);
         end else if (acc_done) begin
            pslverr_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_en && paddr == tla_pkg::TLA_OFF_CTRL && pstrb[0]) begin
         ctrl_nxt = pwdata[tla_pkg::TLA_CTRL_W-1:0]; // see RULE1
      end
   end

   assign mode_chg = ctrl_nxt[tla_pkg::TLA_CTRL_COMP] != comp_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tla_pkg::TLA_CTRL_RST; // see RULE2
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_r <= tla_pkg::TLA_UPPER_RST;
         lower_r <= tla_pkg::TLA_LOWER_RST;
         crit_r <= tla_pkg::TLA_CRIT_RST;
         hyst_r <= tla_pkg::TLA_HYST_RST;
         mask_r <= tla_pkg::TLA_MASK_RST;
      end else if (wr_en) begin
         case (paddr)
            tla_pkg::TLA_OFF_UPPER: begin
               upper_r <= tla_merge16(upper_r, pwdata, pstrb);
            end
            tla_pkg::TLA_OFF_LOWER: begin
               lower_r <= tla_merge16(lower_r, pwdata, pstrb);
            end
            tla_pkg::TLA_OFF_CRIT: begin
               crit_r <= tla_merge16(crit_r, pwdata, pstrb);
            end
            tla_pkg::TLA_OFF_HYST: begin
               hyst_r <= tla_merge16(hyst_r, pwdata, pstrb);
            end
            tla_pkg::TLA_OFF_IRQ_MASK: begin
               if (pstrb[0]) begin
                  mask_r <= pwdata[tla_pkg::TLA_EV_W-1:0];
               end
            end
            default: begin
               mask_r <= mask_r;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion capture

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_r <= tla_pkg::TLA_TEMP_RST;
         eval_r <= 1'b0;
      end else begin
         eval_r <= conv_valid && !shutdown; // see RULE10
         if (conv_valid && !shutdown) begin
            temp_r <= conv_result;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_clr_r <= 1'b0;
      end else begin
         rd_clr_r <= rd_en; // see RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Limit checks

   tla_limit_core u_alarm (
      .pclk(pclk),
      .presetn(presetn),
      .eval(eval_r),
      .temp(temp_r),
      .upper(upper_r),
      .lower(lower_r),
      .hyst(hyst_r),
      .lower_en(1'b1),
      .comp_mode(comp_mode),
      .shutdown(shutdown),
      .rd_clr(rd_clr_r),
      .mode_chg(mode_chg),
      .alarm(a_alarm),
      .over_r(a_over),
      .under_r(a_under),
      .over_evt(a_over_evt),
      .under_evt(a_under_evt)
   );

   tla_limit_core u_crit (
      .pclk(pclk),
      .presetn(presetn),
      .eval(eval_r),
      .temp(temp_r),
      .upper(crit_r),
      .lower(lower_r),
      .hyst(hyst_r),
      .lower_en(1'b0),
      .comp_mode(comp_mode),
      .shutdown(shutdown),
      .rd_clr(rd_clr_r),
      .mode_chg(mode_chg),
      .alarm(c_alarm),
      .over_r(c_over),
      .under_r(c_under_unused),
      .over_evt(c_over_evt),
      .under_evt(c_under_evt_unused)
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   always_comb begin
      events = 4'h0;
      events[tla_pkg::TLA_EV_OVER] = a_over_evt;
      events[tla_pkg::TLA_EV_UNDER] = a_under_evt;
      events[tla_pkg::TLA_EV_CRIT] = c_over_evt;
      events[tla_pkg::TLA_EV_CONV] = eval_r;
   end

   tla_irq_ctrl u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .events(events),
      .wr_clr(wr_en && paddr == tla_pkg::TLA_OFF_IRQ_STAT && pstrb[0]),
      .clr_bits(pwdata[tla_pkg::TLA_EV_W-1:0]),
      .mask(mask_r),
      .stat_r(irq_stat),
      .irq_r(irq_r)
   );

   ////////////////////////////////////////////////////////////////////////
   // Open-drain pins

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_oe_n_r <= 1'b1;
         crit_oe_n_r <= 1'b1;
      end else begin
         // Pull low when the level means active-low asserted or active-high idle
         alarm_oe_n_r <= a_alarm ~^ ctrl_r[tla_pkg::TLA_CTRL_APOL]; // see RULE9
         crit_oe_n_r <= c_alarm ~^ ctrl_r[tla_pkg::TLA_CTRL_CPOL]; // see RULE9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      status = '0;
      status[tla_pkg::TLA_ST_ALARM] = a_alarm;
      status[tla_pkg::TLA_ST_OVER] = a_over;
      status[tla_pkg::TLA_ST_UNDER] = a_under;
      status[tla_pkg::TLA_ST_CRIT] = c_over;
      status[tla_pkg::TLA_ST_APIN] = alarm_pin_in;
      status[tla_pkg::TLA_ST_CPIN] = critical_alarm_output_in;
   end

   always_comb begin
      rd_mux = 32'h0;
      case (paddr)
         tla_pkg::TLA_OFF_CTRL: begin
            rd_mux[tla_pkg::TLA_CTRL_W-1:0] = ctrl_r;
         end
         tla_pkg::TLA_OFF_UPPER: begin
            rd_mux[15:0] = upper_r;
         end
         tla_pkg::TLA_OFF_LOWER: begin
            rd_mux[15:0] = lower_r;
         end
         tla_pkg::TLA_OFF_CRIT: begin
            rd_mux[15:0] = crit_r;
         end
         tla_pkg::TLA_OFF_HYST: begin
            rd_mux[15:0] = hyst_r;
         end
         tla_pkg::TLA_OFF_TEMP: begin
            rd_mux[15:0] = temp_r;
         end
         tla_pkg::TLA_OFF_STATUS: begin
            rd_mux[tla_pkg::TLA_ST_W-1:0] = status;
         end
         tla_pkg::TLA_OFF_IRQ_STAT: begin
            rd_mux[tla_pkg::TLA_EV_W-1:0] = irq_stat;
         end
         tla_pkg::TLA_OFF_IRQ_MASK: begin
            rd_mux[tla_pkg::TLA_EV_W-1:0] = mask_r;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign alarm_pin_oe_n = alarm_oe_n_r;
   assign critical_alarm_output_oe_n = crit_oe_n_r;
   assign alarm_pin_out = 1'b0;
   assign critical_alarm_output_out = 1'b0;

endmodule

// ===== verif/tla_top_sva.sv
// Checker on the ports of tla_top.
// Assumes one clock domain, pclk, with presetn as async reset.
`timescale 1ns/1ps
module tla_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_valid,
   input wire logic [15:0] conv_result,
   input wire logic alarm_pin_in,
   input wire logic alarm_pin_out,
   input wire logic alarm_pin_oe_n,
   input wire logic critical_alarm_output_in,
   input wire logic critical_alarm_output_out,
   input wire logic critical_alarm_output_oe_n,
   input wire logic irq
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
// Recent conversion or bus access
logic [3:0] act_r;
always_ff @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      act_r <= 4'h0;
   end else begin
      act_r <= {act_r[2:0], conv_valid | (psel & penable)};
   end
end
////////////////////////////////////////////////////////////////////////////////
pin_low_a: assert property (alarm_pin_out == 1'b0) else $error("alarm pin drives high");
crit_low_a: assert property (critical_alarm_output_out == 1'b0) else $error("crit pin drives high");
pin_cause_a: assert property ($changed(alarm_pin_oe_n) |-> act_r != 4'h0)
   else $error("alarm pin moved alone");
crit_cause_a: assert property ($changed(critical_alarm_output_oe_n) |-> act_r != 4'h0)
   else $error("crit moved alone");
ready_next_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
ready_setup_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
err_access_a: assert property (pslverr |-> pready && psel && penable) else $error("error outside access");
unmap_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read data");
irq_fall_a: assert property ($fell(irq) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
   else $error("irq fell without write");
irq_rise_a: assert property ($rose(irq) |-> act_r != 4'h0) else $error("irq rose alone");
cover property ($rose(irq));
cover property ($fell(alarm_pin_oe_n));
cover property (pslverr);
endmodule

bind tla_top tla_top_sva u_tla_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .conv_valid(conv_valid), .conv_result(conv_result), .alarm_pin_in(alarm_pin_in),
   .alarm_pin_out(alarm_pin_out), .alarm_pin_oe_n(alarm_pin_oe_n),
   .critical_alarm_output_in(critical_alarm_output_in), .critical_alarm_output_out(critical_alarm_output_out),
   .critical_alarm_output_oe_n(critical_alarm_output_oe_n), .irq(irq));

// ===== verif/tla_host_model.sv
// Host side of the two open-drain alarm lines.
// Assumes a pull-up on each line; low only while the block pulls it.
`timescale 1ns/1ps
module tla_host_model (
   input wire logic alarm_pin_out,
   input wire logic alarm_pin_oe_n,
   input wire logic crit_out,
   input wire logic crit_oe_n,
   output logic alarm_line,
   output logic crit_line
);
// Pull-up when released
assign alarm_line = alarm_pin_oe_n ? 1'b1 : alarm_pin_out;
assign crit_line = crit_oe_n ? 1'b1 : crit_out;
endmodule

// ===== verif/tla_top_tb.sv
// Self-checking bench for tla_top.
// Assumes the pull-up host model and the bound checker.
`timescale 1ns/1ps
module tla_top_tb;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [3:0] pstrb = 4'hF;
logic conv_valid = 1'b0;
logic [15:0] conv_result = 16'h0;
wire [31:0] prdata;
wire pready, pslverr, a_out, a_oe_n, c_out, c_oe_n, irq, a_line, c_line;
int err_count = 0;
int n_compared = 0;
logic [15:0] lf = 16'hB43F;
logic [15:0] t;
logic [31:0] q;
logic perr;
logic [15:0] corn [7] = '{16'h2000, 16'h2001, 16'h0500, 16'h04FF, 16'hFF00, 16'h7FFF, 16'h8000};
always #4 pclk = ~pclk;
tla_top u_tla_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_valid(conv_valid), .conv_result(conv_result), .alarm_pin_in(a_line), .alarm_pin_out(a_out),
   .alarm_pin_oe_n(a_oe_n), .critical_alarm_output_in(c_line), .critical_alarm_output_out(c_out),
   .critical_alarm_output_oe_n(c_oe_n), .irq(irq));
tla_host_model u_tla_host_model (.alarm_pin_out(a_out), .alarm_pin_oe_n(a_oe_n), .crit_out(c_out),
   .crit_oe_n(c_oe_n), .alarm_line(a_line), .crit_line(c_line));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] lfsr(input logic [15:0] s);
   return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
function automatic logic out_lim(input logic [15:0] v, input logic [15:0] up, input logic [15:0] lo);
   return ($signed(v) > $signed(up)) || ($signed(v) < $signed(lo));
endfunction
task automatic summarize;
   $display("Counts: %0d errors, %0d compared", err_count, n_compared);
   if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
   end else begin
      $display("Finished with errors");
   end
   $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   n_compared++;
   if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
task automatic chk_pin(input logic got, input logic exp);
   chk({31'h0, got}, {31'h0, exp});
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   int n;
   n = 0;
   @(posedge pclk);
   psel <= 1'b1;
   penable <= 1'b0;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1'b1;
   @(posedge pclk);
   while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
         err_count++;
         summarize();
      end
      @(posedge pclk);
   end
   q = prdata;
   perr = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
   apb(1'b1, a, d);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] exp);
   apb(1'b0, a, 32'h0);
   chk(q, exp);
   repeat (4) @(posedge pclk);
endtask
task automatic conv(input logic [15:0] v);
   @(posedge pclk);
   conv_valid <= 1'b1;
   conv_result <= v;
   @(posedge pclk);
   conv_valid <= 1'b0;
   repeat (4) @(posedge pclk);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   repeat (20) @(posedge pclk);
   presetn <= 1'b1;
   chk_pin(a_line, 1'b1);
   rd(tla_pkg::TLA_OFF_CTRL, 32'h0);
   rd(tla_pkg::TLA_OFF_UPPER, 32'h2000);
   rd(tla_pkg::TLA_OFF_HYST, 32'h0280);
   apb(1'b0, 8'h24, 32'h0);
   chk({31'h0, perr}, 32'h1);
   wr(tla_pkg::TLA_OFF_IRQ_MASK, 32'h1);
   conv(16'h2100);
   chk_pin(irq, 1'b1);
   chk_pin(a_line, 1'b0);
   rd(tla_pkg::TLA_OFF_STATUS, 32'h23);
   chk_pin(a_line, 1'b1);
   rd(tla_pkg::TLA_OFF_IRQ_STAT, 32'h9);
   wr(tla_pkg::TLA_OFF_IRQ_STAT, 32'hF);
   repeat (3) @(posedge pclk);
   chk_pin(irq, 1'b0);
   chk_pin(a_line, 1'b1);
   for (int i = 0; i < 19; i++) begin
      lf = lfsr(lf);
      t = (i < 7) ? corn[i] : lf;
      conv(t);
      chk_pin(a_line, !out_lim(t, 16'h2000, 16'h0500));
      chk_pin(c_line, !($signed(t) > $signed(16'h4000)));
      rd(tla_pkg::TLA_OFF_TEMP, {16'h0, t});
      chk_pin(a_line, 1'b1);
   end
   conv(16'h2100);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h8);
   repeat (4) @(posedge pclk);
   chk_pin(a_line, 1'b1);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h1);
   conv(16'h2100);
   rd(tla_pkg::TLA_OFF_CTRL, 32'h1);
   chk_pin(a_line, 1'b0);
   conv(16'h1D80);
   chk_pin(a_line, 1'b0);
   conv(16'h1D7F);
   chk_pin(a_line, 1'b1);
   conv(16'h2100);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h9);
   repeat (4) @(posedge pclk);
   chk_pin(a_line, 1'b0);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h1);
   conv(16'h0400);
   conv(16'h0780);
   chk_pin(a_line, 1'b0);
   conv(16'h0781);
   chk_pin(a_line, 1'b1);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h2);
   repeat (4) @(posedge pclk);
   chk_pin(a_line, 1'b0);
   conv(16'h2100);
   chk_pin(a_line, 1'b1);
   pstrb <= 4'h0;
   wr(tla_pkg::TLA_OFF_CTRL, 32'h1);
   pstrb <= 4'hF;
   rd(tla_pkg::TLA_OFF_CTRL, 32'h2);
   chk_pin(a_line, 1'b0);
   wr(tla_pkg::TLA_OFF_CTRL, 32'h6);
   repeat (4) @(posedge pclk);
   chk_pin(c_line, 1'b0);
   conv(16'h4001);
   chk_pin(c_line, 1'b1);
   chk_pin(a_line, 1'b1);
   summarize();
end
endmodule
